/* hw/dbc_top.sv */
// DMA bus configuration: staging FIFO, register, ready qualification, wait states, bursts
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps

// Small valid/ready FIFO between the MAC side and the DMA data path
module dbc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    // Pointers and fill count together; the words themselves sit in the array
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
    } dbc_fifo_s;
    dbc_fifo_s f_q;
    dbc_fifo_s f_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic push;
    logic pop;

    // Honest full and empty straight from the count
    assign in_ready = (f_q.cnt != CW'(DEPTH));
    assign out_valid = (f_q.cnt != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[f_q.rd];
    assign level = f_q.cnt;

    // Pointers wrap at the depth, which need not be a power of two
    always_comb begin
        f_d = f_q;
        if (push) begin
            f_d.wr = (f_q.wr == AW'(DEPTH - 1)) ? '0 : f_q.wr + 1'b1;
        end
        if (pop) begin
            f_d.rd = (f_q.rd == AW'(DEPTH - 1)) ? '0 : f_q.rd + 1'b1;
        end
        f_d.cnt = f_q.cnt + CW'(push) - CW'(pop);
    end

    // Storage is not reset; the count alone says which words are live
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[f_q.wr] <= in_data;
        end
    end

    // Pointer and count register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end
endmodule // dbc_fifo

module dbc_top #(
    parameter int DATA_W = 32,
    parameter int BUF_DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic srst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Straps and memory-side ready
    input wire logic [1:0] user_strap_pins,
    input wire logic bus_mode_pin,
    input wire dbc_pkg::dbc_rdy_s rdy_in,
    // FIFO occupancy in units, from the MAC side
    input wire logic [4:0] rx_fifo_count,
    input wire logic [4:0] tx_fifo_count,
    // Memory cycle outputs
    output logic rx_dma_req,
    output logic tx_dma_req,
    output logic mem_cycle,
    output logic mem_dir_tx,
    output logic [1:0] bus_state,
    output logic wide_path,
    // Data staging buffer toward memory
    input wire logic data_in_valid,
    output logic data_in_ready,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] mem_wdata
);
    // State of the block, apart from the falling-edge synchroniser and the staging FIFO
    typedef struct packed {
        dbc_pkg::dbc_cfg_s cfg;
        dbc_pkg::dbc_bus_e st;
        logic tx;
        logic [1:0] waits;
        logic [2:0] clks;
        logic [4:0] moved;
        logic rdy_meta;
        logic rdy_sync;
        logic rd_pend;
        logic [15:0] rdata;
        logic strap_pend;
        logic [DATA_W-1:0] wdata;
    } dbc_state_s;

    dbc_state_s s_q;
    dbc_state_s s_d;
    logic fall_meta_q;
    logic fall_sync_q;
    logic raw_ready;
    logic ready_now;
    logic [3:0] rx_thr;
    logic [3:0] tx_thr;
    logic [4:0] cap;
    logic beat_done;
    logic burst_end;
    logic buf_valid;
    logic buf_pop;
    logic [DATA_W-1:0] buf_data;
    localparam int LW = $clog2(BUF_DEPTH + 1);
    logic [LW-1:0] buf_level;
    logic [15:0] cfg_wr;

    // Threshold decode, in words or long words by path width
    function automatic logic [3:0] thr_units(input logic rx, input logic [1:0] code,
                                             input logic wide);
        logic [3:0] t;
        t = 4'h0;
        case ({rx, wide, code})
            4'b1000: t = dbc_pkg::RX_THR_W0;
            4'b1001: t = dbc_pkg::RX_THR_W1;
            4'b1010: t = dbc_pkg::RX_THR_W2;
            4'b1011: t = dbc_pkg::RX_THR_W3;
            4'b1100: t = dbc_pkg::RX_THR_L0;
            4'b1101: t = dbc_pkg::RX_THR_L1;
            4'b1110: t = dbc_pkg::RX_THR_L2;
            4'b1111: t = dbc_pkg::RX_THR_L3;
            4'b0000: t = dbc_pkg::TX_THR_W0;
            4'b0001: t = dbc_pkg::TX_THR_W1;
            4'b0010: t = dbc_pkg::TX_THR_W2;
            4'b0011: t = dbc_pkg::TX_THR_W3;
            4'b0100: t = dbc_pkg::TX_THR_L0;
            4'b0101: t = dbc_pkg::TX_THR_L1;
            4'b0110: t = dbc_pkg::TX_THR_L2;
            default: t = dbc_pkg::TX_THR_L3;
        endcase
        return t;
    endfunction

    assign rx_thr = thr_units(1'b1, s_q.cfg.rx_fifo_level, s_q.cfg.path_width_select);
    assign tx_thr = thr_units(1'b0, s_q.cfg.tx_fifo_level, s_q.cfg.path_width_select);
    assign cap = s_q.cfg.path_width_select ? dbc_pkg::FIFO_LONGS : dbc_pkg::FIFO_WORDS;

    // Strap bits are not writable; the captured pair is folded back in
    assign cfg_wr = (reg_wdata & dbc_pkg::CONFIG_WMASK)
                  | ({14'h0, s_q.cfg.user_strap_bits} << dbc_pkg::USR_LO);

    // Ready source chosen by bus mode; either ack low means terminate
    assign raw_ready = bus_mode_pin ? ~(rdy_in.size_ack_inputs[0] & rdy_in.size_ack_inputs[1])
                                    : rdy_in.ready_input;

    // Falling-edge synchroniser; first stage feeds only the second
    always_ff @(negedge sys_clk) begin
        if (srst) begin
            fall_meta_q <= 1'b0;
            fall_sync_q <= 1'b0;
        end else begin
            fall_meta_q <= raw_ready;
            fall_sync_q <= fall_meta_q;
        end
    end

    // Async mode also requires the three-clock floor before ending
    assign ready_now = s_q.cfg.sync_ready_select ? raw_ready
                     : (s_q.rdy_sync && s_q.clks >= dbc_pkg::ASYNC_MIN_CLKS - 3'h1);

    assign beat_done = (s_q.st == dbc_pkg::DBC_ST2) && (s_q.waits == 2'h0) && ready_now;

    // End of burst: block mode counts threshold, empty/fill mode watches the FIFO
    always_comb begin
        if (s_q.cfg.burst_mode_select) begin
            burst_end = s_q.tx ? (s_q.moved + 5'h1 >= {1'b0, tx_thr})
                               : (s_q.moved + 5'h1 >= {1'b0, rx_thr});
        end else begin
            burst_end = s_q.tx ? (tx_fifo_count + 5'h1 >= cap)
                               : (rx_fifo_count <= 5'h1);
        end
    end

    assign rx_dma_req = rx_fifo_count >= {1'b0, rx_thr};
    assign tx_dma_req = tx_fifo_count < {1'b0, tx_thr};
    assign buf_pop = beat_done && !s_q.tx && buf_valid;

    dbc_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .sys_clk(sys_clk),
        .srst(srst),
        .in_valid(data_in_valid),
        .in_ready(data_in_ready),
        .in_data(data_in),
        .out_valid(buf_valid),
        .out_ready(buf_pop),
        .out_data(buf_data),
        .level(buf_level)
    );

    // Next-state logic: register port, strap capture, memory cycle sequencing
    always_comb begin
        s_d = s_q;
        s_d.rd_pend = 1'b0;
        s_d.rdy_meta = 1'b0;
        s_d.rdy_sync = fall_sync_q;
        if (reg_wr && reg_addr == dbc_pkg::ADDR_CONFIG) begin
            s_d.cfg = dbc_pkg::dbc_cfg_s'(cfg_wr[10:0]);
        end
        if (s_q.strap_pend) begin
            s_d.cfg.user_strap_bits = user_strap_pins;
            s_d.strap_pend = 1'b0;
        end
        if (reg_rd) begin
            s_d.rd_pend = 1'b1;
            case (reg_addr)
                dbc_pkg::ADDR_CONFIG: s_d.rdata = {5'h0, s_q.cfg};
                dbc_pkg::ADDR_STATUS: s_d.rdata = {10'h0, s_q.tx, s_q.moved};
                default: s_d.rdata = 16'h0000;
            endcase
        end
        case (s_q.st)
            dbc_pkg::DBC_IDLE: begin
                s_d.moved = 5'h0;
                s_d.clks = 3'h0;
                if (rx_dma_req && buf_valid) begin
                    s_d.st = dbc_pkg::DBC_ST1;
                    s_d.tx = 1'b0;
                end else if (tx_dma_req) begin
                    s_d.st = dbc_pkg::DBC_ST1;
                    s_d.tx = 1'b1;
                end
            end
            dbc_pkg::DBC_ST1: begin
                s_d.st = dbc_pkg::DBC_ST2;
                s_d.waits = s_q.cfg.wait_state_count;
                s_d.clks = 3'h1;
                if (!s_q.tx) begin
                    s_d.wdata = buf_data;
                end
            end
            dbc_pkg::DBC_ST2: begin
                if (s_q.clks != 3'h7) begin
                    s_d.clks = s_q.clks + 3'h1;
                end
                if (s_q.waits != 2'h0) begin
                    s_d.waits = s_q.waits - 2'h1;
                end else if (beat_done) begin
                    s_d.moved = s_q.moved + 5'h1;
                    s_d.clks = 3'h0;
                    // Receive stops on the beat that takes the last buffered word
                    if (burst_end || (!s_q.tx && buf_level <= LW'(1))) begin
                        s_d.st = dbc_pkg::DBC_IDLE;
                    end else begin
                        s_d.st = dbc_pkg::DBC_ST1;
                    end
                end
            end
            default: s_d.st = dbc_pkg::DBC_IDLE;
        endcase
    end

    // Reset loads constants; straps are caught on the first edge after release
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.cfg <= dbc_pkg::dbc_cfg_s'(dbc_pkg::CONFIG_RESET[10:0]);
            s_q.st <= dbc_pkg::DBC_IDLE;
            s_q.strap_pend <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rd_pend ? s_q.rdata : 16'h0000;
    assign mem_cycle = s_q.st != dbc_pkg::DBC_IDLE;
    assign mem_dir_tx = s_q.tx;
    assign bus_state = s_q.st;
    assign wide_path = s_q.cfg.path_width_select;
    // Narrow path keeps the upper half quiet
    assign mem_wdata = s_q.cfg.path_width_select ? s_q.wdata
                     : {{(DATA_W-16){1'b0}}, s_q.wdata[15:0]};

    // Async cycle length from first state to the ending edge
    a_async_floor: assert property (@(posedge sys_clk) disable iff (srst)
        beat_done && !s_q.cfg.sync_ready_select |-> s_q.clks >= 3'h2)
        else $error("async memory cycle shorter than three clocks");

    a_wait_insert: assert property (@(posedge sys_clk) disable iff (srst)
        s_q.st == dbc_pkg::DBC_ST1 && s_q.cfg.wait_state_count == 2'h3
        |=> !beat_done [*3])
        else $error("wait states not inserted");

    a_strap_hold: assert property (@(posedge sys_clk) disable iff (srst)
        !s_q.strap_pend && !$past(s_q.strap_pend) |-> $stable(s_q.cfg.user_strap_bits))
        else $error("strap bits changed after capture");

    a_strap_take: assert property (@(posedge sys_clk) disable iff (srst)
        s_q.strap_pend |=> s_q.cfg.user_strap_bits == $past(user_strap_pins))
        else $error("strap bits not captured");

    a_rx_request: assert property (@(posedge sys_clk) disable iff (srst)
        rx_fifo_count >= {1'b0, rx_thr} |-> rx_dma_req)
        else $error("receive request missing");

    a_tx_request: assert property (@(posedge sys_clk) disable iff (srst)
        tx_dma_req |-> tx_fifo_count < {1'b0, tx_thr})
        else $error("transmit request without low level");

    // Last beat of a block burst, followed by the return to idle
    sequence s_last_beat;
        beat_done && s_q.cfg.burst_mode_select;
    endsequence

    sequence s_back_idle;
        s_q.st == dbc_pkg::DBC_IDLE;
    endsequence

    // Threshold taken from the beat cycle, so a config write there cannot confuse it
    a_block_count: assert property (@(posedge sys_clk) disable iff (srst)
        s_last_beat ##1 s_back_idle
        |-> $past(s_q.moved) + 5'h1 >= {1'b0, $past(s_q.tx ? tx_thr : rx_thr)}
            || $past(!s_q.tx && buf_level <= LW'(1)))
        else $error("block burst ended early");

    a_block_max: assert property (@(posedge sys_clk) disable iff (srst)
        s_q.cfg.burst_mode_select && !s_q.tx && mem_cycle |-> s_q.moved <= {1'b0, rx_thr})
        else $error("receive burst exceeded threshold");

    a_path_width: assert property (@(posedge sys_clk) disable iff (srst)
        !wide_path |-> mem_wdata[DATA_W-1:16] == '0)
        else $error("narrow path drove upper half");

    // Beat sequencing and ready qualification
    a_rx_has_data: assert property (@(posedge sys_clk) disable iff (srst)
        beat_done && !s_q.tx |-> buf_valid)
        else $error("receive beat without buffered data");

    a_sync_direct: assert property (@(posedge sys_clk) disable iff (srst)
        s_q.cfg.sync_ready_select && s_q.st == dbc_pkg::DBC_ST2 && s_q.waits == 2'h0
        && raw_ready |-> beat_done)
        else $error("synchronous ready not taken");

    a_async_path: assert property (@(posedge sys_clk) disable iff (srst)
        !s_q.cfg.sync_ready_select && beat_done |-> s_q.rdy_sync)
        else $error("asynchronous ready bypassed synchroniser");

    a_state_one: assert property (@(posedge sys_clk) disable iff (srst)
        s_q.st == dbc_pkg::DBC_ST1
        |=> s_q.st == dbc_pkg::DBC_ST2 && s_q.waits == $past(s_q.cfg.wait_state_count))
        else $error("state two not entered with wait count");

    a_ready_source: assert property (@(posedge sys_clk) disable iff (srst)
        raw_ready == (bus_mode_pin ? rdy_in.size_ack_inputs != 2'h3 : rdy_in.ready_input))
        else $error("wrong ready source for bus mode");

    a_idle_quiet: assert property (@(posedge sys_clk) disable iff (srst)
        s_q.st == dbc_pkg::DBC_IDLE && !(rx_dma_req && buf_valid) && !tx_dma_req
        |=> s_q.st == dbc_pkg::DBC_IDLE)
        else $error("memory cycle started without request");
endmodule // dbc_top

/* pkg/dbc_pkg.sv */
// Package for the DMA bus configuration block: register layout, encodings, timing
package dbc_pkg;
    // Register map (word addresses of the plain register port)
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    // Configuration register field positions
    localparam int TFT_LO = 0;
    localparam int RFT_LO = 2;
    localparam int BMS_BIT = 4;
    localparam int DW_BIT = 5;
    localparam int WC_LO = 6;
    localparam int USR_LO = 8;
    localparam int SYNC_READY_SELECT_BIT = 10;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [15:0] CONFIG_WMASK = 16'h04FF;
    // Memory cycle floor in asynchronous ready mode, in bus clocks
    localparam logic [2:0] ASYNC_MIN_CLKS = 3'h3;
    // Receive and transmit thresholds in units (words or long words), per encoding
    localparam logic [3:0] RX_THR_W0 = 4'h2;
    localparam logic [3:0] RX_THR_W1 = 4'h4;
    localparam logic [3:0] RX_THR_W2 = 4'h8;
    localparam logic [3:0] RX_THR_W3 = 4'hC;
    localparam logic [3:0] RX_THR_L0 = 4'h1;
    localparam logic [3:0] RX_THR_L1 = 4'h2;
    localparam logic [3:0] RX_THR_L2 = 4'h4;
    localparam logic [3:0] RX_THR_L3 = 4'h6;
    localparam logic [3:0] TX_THR_W0 = 4'h4;
    localparam logic [3:0] TX_THR_W1 = 4'h8;
    localparam logic [3:0] TX_THR_W2 = 4'hC;
    localparam logic [3:0] TX_THR_W3 = 4'hE;
    localparam logic [3:0] TX_THR_L0 = 4'h2;
    localparam logic [3:0] TX_THR_L1 = 4'h4;
    localparam logic [3:0] TX_THR_L2 = 4'h6;
    localparam logic [3:0] TX_THR_L3 = 4'h7;
    // FIFO capacity in units; 32 bytes is 16 words or 8 long words
    localparam logic [4:0] FIFO_WORDS = 5'h10;
    localparam logic [4:0] FIFO_LONGS = 5'h08;

    // Memory cycle states
    typedef enum logic [1:0] {
        DBC_IDLE,
        DBC_ST1,
        DBC_ST2
    } dbc_bus_e;

    // Configuration fields as software sees them
    typedef struct packed {
        logic sync_ready_select;
        logic [1:0] user_strap_bits;
        logic [1:0] wait_state_count;
        logic path_width_select;
        logic burst_mode_select;
        logic [1:0] rx_fifo_level;
        logic [1:0] tx_fifo_level;
    } dbc_cfg_s;

    // Memory side ready inputs
    typedef struct packed {
        logic ready_input;
        logic [1:0] size_ack_inputs;
    } dbc_rdy_s;
endpackage

/* hw/dbc_fifo.sv */
// Intentionally empty: the staging FIFO module is defined with the top level in dbc_top.sv

/* tb/dbc_mem_model.sv */
// Memory-side ready model: answers each state-two beat after a set delay
`timescale 1ns/1ps
module dbc_mem_model (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic bus_mode_pin,
    input wire logic [1:0] bus_state,
    input wire logic [3:0] delay,
    output dbc_pkg::dbc_rdy_s rdy_in
);
    logic [3:0] wait_q;
    logic go;
    // Cycles already spent in state two; cleared between beats
    always_ff @(posedge sys_clk) begin
        if (srst || bus_state != 2'h2) begin
            wait_q <= 4'h0;
        end else if (wait_q != 4'hF) begin
            wait_q <= wait_q + 4'h1;
        end
    end
    assign go = (bus_state == 2'h2) && (wait_q >= delay);
    // Only the selected input answers, so a wrong pick stalls the beat
    always_comb begin
        rdy_in.ready_input = go && !bus_mode_pin;
        rdy_in.size_ack_inputs = (go && bus_mode_pin) ? 2'h0 : 2'h3;
    end
endmodule // dbc_mem_model

/* tb/dma_bus_configuration_test.sv */
// Self-checking bench for the DMA bus configuration block
`timescale 1ns/1ps
module dma_bus_configuration_test;
    typedef struct packed {
        logic [15:0] cfg;
        logic [4:0] rxc;
        logic [4:0] txc;
        logic rxr;
        logic txr;
    } dbc_row_s;
    logic sys_clk, srst, reg_wr, reg_rd, bus_mode_pin, rx_dma_req, tx_dma_req;
    logic mem_cycle, mem_dir_tx, wide_path, data_in_valid, data_in_ready;
    logic [3:0] reg_addr, delay;
    logic [15:0] reg_wdata, reg_rdata, v;
    logic [1:0] user_strap_pins, bus_state;
    logic [4:0] rx_fifo_count, tx_fifo_count;
    logic [31:0] data_in, mem_wdata;
    dbc_pkg::dbc_rdy_s rdy_in;
    int bad_count = 0, n_tests = 0, cyc = 0, n, i;
    // Threshold table: words on the narrow path, long words on the wide one
    dbc_row_s rows [10] = '{
        '{16'h0000, 5'h02, 5'h03, 1'b1, 1'b1}, '{16'h0000, 5'h01, 5'h04, 1'b0, 1'b0},
        '{16'h0005, 5'h03, 5'h07, 1'b0, 1'b1}, '{16'h0005, 5'h04, 5'h08, 1'b1, 1'b0},
        '{16'h000A, 5'h08, 5'h0C, 1'b1, 1'b0}, '{16'h000F, 5'h0B, 5'h0D, 1'b0, 1'b1},
        '{16'h0020, 5'h01, 5'h02, 1'b1, 1'b0}, '{16'h0025, 5'h01, 5'h03, 1'b0, 1'b1},
        '{16'h002A, 5'h04, 5'h06, 1'b1, 1'b0}, '{16'h002F, 5'h05, 5'h06, 1'b0, 1'b1}};
    dbc_top #(.DATA_W(32), .BUF_DEPTH(4)) dut_u (.sys_clk(sys_clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .user_strap_pins(user_strap_pins),
        .bus_mode_pin(bus_mode_pin), .rdy_in(rdy_in), .rx_fifo_count(rx_fifo_count),
        .tx_fifo_count(tx_fifo_count), .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req),
        .mem_cycle(mem_cycle), .mem_dir_tx(mem_dir_tx), .bus_state(bus_state),
        .wide_path(wide_path), .data_in_valid(data_in_valid),
        .data_in_ready(data_in_ready), .data_in(data_in), .mem_wdata(mem_wdata));
    dbc_mem_model mem_u (.sys_clk(sys_clk), .srst(srst), .bus_mode_pin(bus_mode_pin),
        .bus_state(bus_state), .delay(delay), .rdy_in(rdy_in));
    // 40 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Hang guard, well above the expected run length
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
    task automatic cnt(input logic [4:0] r, input logic [4:0] t);
        @(posedge sys_clk);
        rx_fifo_count <= r;
        tx_fifo_count <= t;
    endtask
    // Length of the next full state-two run, sampled at falling edges
    task automatic st2_len(output int len);
        int k;
        len = 0;
        for (k = 0; k < 200 && bus_state === 2'h2; k++) @(negedge sys_clk);
        for (k = 0; k < 200 && bus_state !== 2'h2; k++) @(negedge sys_clk);
        while (len < 50 && bus_state === 2'h2) begin
            len++;
            @(negedge sys_clk);
        end
    endtask
    // Beats of the next whole burst: one state-one cycle per beat
    task automatic beats(output int b);
        int k;
        b = 0;
        for (k = 0; k < 200 && mem_cycle !== 1'b0; k++) @(negedge sys_clk);
        for (k = 0; k < 200 && mem_cycle !== 1'b1; k++) @(negedge sys_clk);
        for (k = 0; k < 200 && mem_cycle === 1'b1; k++) begin
            if (bus_state === 2'h1) b++;
            @(negedge sys_clk);
        end
    endtask
    task automatic push(input logic [31:0] w);
        int k;
        @(posedge sys_clk);
        data_in_valid <= 1'b1;
        data_in <= w;
        for (k = 0; k < 50; k++) begin
            @(negedge sys_clk);
            if (data_in_ready === 1'b1) break;
        end
        @(posedge sys_clk);
        data_in_valid <= 1'b0;
    endtask
    task automatic settle();
        int k;
        for (k = 0; k < 300 && !(mem_cycle === 1'b0 && data_in_ready === 1'b1); k++)
            @(negedge sys_clk);
    endtask
    // Main sequence
    initial begin
        srst = 1'b1;
        {reg_wr, reg_rd, bus_mode_pin, data_in_valid} = 4'h0;
        {reg_addr, delay, reg_wdata, data_in} = '0;
        {rx_fifo_count, tx_fifo_count} = 10'h000;
        user_strap_pins = 2'h2;
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        user_strap_pins <= 2'h1;
        rd(dbc_pkg::ADDR_CONFIG, v);
        chk(v, 16'h0200);
        wr(dbc_pkg::ADDR_CONFIG, 16'hFFFF);
        rd(dbc_pkg::ADDR_CONFIG, v);
        chk(v, 16'h06FF);
        rd(4'h7, v);
        chk(v, 16'h0000);
        $display("test registers done");
        for (i = 0; i < 10; i++) begin
            wr(dbc_pkg::ADDR_CONFIG, rows[i].cfg);
            cnt(rows[i].rxc, rows[i].txc);
            @(negedge sys_clk);
            chk({15'h0, rx_dma_req}, {15'h0, rows[i].rxr});
            chk({15'h0, tx_dma_req}, {15'h0, rows[i].txr});
            chk({15'h0, wide_path}, {15'h0, rows[i].cfg[5]});
        end
        $display("test thresholds done");
        cnt(5'h00, 5'h00);
        for (i = 0; i < 4; i++) begin
            wr(dbc_pkg::ADDR_CONFIG, 16'h0400 | 16'(i << 6));
            st2_len(n);
            st2_len(n);
            chk(16'(n), 16'(i + 1));
        end
        @(posedge sys_clk);
        bus_mode_pin <= 1'b1;
        st2_len(n);
        st2_len(n);
        chk(16'(n), 16'h0004);
        wr(dbc_pkg::ADDR_CONFIG, 16'h0400);
        @(posedge sys_clk);
        delay <= 4'h3;
        st2_len(n);
        st2_len(n);
        chk(16'(n), 16'h0004);
        wr(dbc_pkg::ADDR_CONFIG, 16'h0000);
        for (i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            bus_mode_pin <= i[0];
            delay <= 4'h0;
            st2_len(n);
            st2_len(n);
            chk(16'(n >= 2), 16'h0001);
        end
        $display("test ready modes done");
        for (i = 0; i < 4; i++) begin
            wr(dbc_pkg::ADDR_CONFIG, 16'h0410 | 16'(i));
            beats(n);
            beats(n);
            chk(16'(n), 16'(i == 3 ? 14 : 4 * (i + 1)));
            chk({15'h0, mem_dir_tx}, 16'h0001);
        end
        wr(dbc_pkg::ADDR_CONFIG, 16'h0433);
        beats(n);
        beats(n);
        chk(16'(n), 16'h0007);
        $display("test block bursts done");
        wr(dbc_pkg::ADDR_CONFIG, 16'h0420);
        cnt(5'h00, 5'h07);
        settle();
        for (i = 0; i < 4; i++) push(32'hA5A50000 + 32'(i));
        @(posedge sys_clk);
        data_in_valid <= 1'b1;
        data_in <= 32'h5A5A5A5A;
        @(negedge sys_clk);
        chk({15'h0, data_in_ready}, 16'h0000);
        @(posedge sys_clk);
        data_in_valid <= 1'b0;
        cnt(5'h01, 5'h07);
        // Four one-beat bursts; the idle gaps between them would fool settle()
        repeat (40) @(negedge sys_clk);
        chk({15'h0, mem_cycle}, 16'h0000);
        chk({15'h0, mem_dir_tx}, 16'h0000);
        chk(mem_wdata[15:0], 16'h0003);
        chk(mem_wdata[31:16], 16'hA5A5);
        cnt(5'h00, 5'h07);
        $display("test buffer done");
        // Mid-run reset recaptures the straps, now 01
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        rd(dbc_pkg::ADDR_CONFIG, v);
        chk(v, 16'h0100);
        chk({15'h0, mem_cycle}, 16'h0000);
        $display("test reset done");
        give_verdict();
    end
endmodule // dma_bus_configuration_test
